// File: shared/dpmb_pkg.sv
// constants shared by the dual-port mailbox host controller
package dpmb_pkg;
  // access timing at 125 MHz (8 ns period)
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_SETUP_NS    = 15;  // address / select set-up before strobe
  localparam int T_PULSE_NS    = 20;  // write strobe or read pulse width
  localparam int T_HOLD_NS     = 10;  // deselect time between accesses
  localparam int T_FLOW_NS     = 30;  // cross-port flow-through wait
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYC = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC  = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOW_CYC  = (T_FLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W     = 4;
  // token latch field
  localparam int TOKEN_ADDR_W = 3;
  localparam int TOKEN_BIT    = 0;
  // idle pin levels after reset
  localparam logic STROBE_IDLE = 1'b1;
  // command codes
  typedef enum logic [1:0] {
    DPMB_CMD_RD_MEM,
    DPMB_CMD_WR_MEM,
    DPMB_CMD_RD_TOKEN,
    DPMB_CMD_WR_TOKEN
  } dpmb_cmd_t;
endpackage

// File: rtl/dpmb_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module dpmb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // pin side
  input  wire logic [WIDTH-1:0] pin_in,
  // core side
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      level  <= '1;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule

// File: rtl/dpmb_host.sv
// host controller driving one port of an asynchronous dual-port ram with mailboxes
// Notes on behaviour
// - memory read asserts port select first, output enable after the set-up time
// - token read asserts token select and output enable, port select high
// - a write happens while strobe and a select are low together
// - address only changes while the write strobe is high
// - host never drives data while device drives the pins
// - reading a word the far port just wrote waits the flow-through delay
`timescale 1ns/1ps
module dpmb_host
  import dpmb_pkg::*;
#(
  parameter int  ADDR_W    = 16,
  parameter int  DATA_W    = 9,
  parameter bit  IS_LEFT   = 1'b1,
  parameter bit  WAIT_FLOW = 1'b1
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // command port
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire dpmb_cmd_t         cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic                   rsp_busy_hit,
  // mailbox helpers
  output logic                   mail_pending,
  output logic                   token_owned,
  // device pins
  output logic      [ADDR_W-1:0] dev_addr,
  output logic                   port_select_n,
  output logic                   token_latch_select_n,
  output logic                   write_strobe_n,
  output logic                   out_enable_n,
  input  wire logic [DATA_W-1:0] dev_data_in,
  output logic      [DATA_W-1:0] dev_data_out,
  output logic                   dev_data_oe,
  input  wire logic              dev_busy_n,
  input  wire logic              dev_int_n
);
  typedef enum logic [2:0] {
    DPMB_IDLE, DPMB_SETUP, DPMB_PULSE, DPMB_FLOW, DPMB_HOLD
  } dpmb_state_t;

  // mailbox addresses follow from the top of the chosen array depth
  localparam logic [ADDR_W-1:0] MBOX_RIGHT = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] MBOX_LEFT  = {{(ADDR_W-1){1'b1}}, 1'b0};
  localparam logic [ADDR_W-1:0] MBOX_OWN   = IS_LEFT ? MBOX_LEFT : MBOX_RIGHT;

  function automatic logic is_write(input dpmb_cmd_t op);
    return op == DPMB_CMD_WR_MEM || op == DPMB_CMD_WR_TOKEN;
  endfunction

  function automatic logic is_token(input dpmb_cmd_t op);
    return op == DPMB_CMD_RD_TOKEN || op == DPMB_CMD_WR_TOKEN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs
  logic [DATA_W+1:0] sync_out;
  logic [DATA_W-1:0] data_s;
  logic              busy_s;
  logic              int_s;

  dpmb_sync #(.WIDTH(DATA_W + 2)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({dev_int_n, dev_busy_n, dev_data_in}),
    .level    (sync_out)
  );
  assign data_s = sync_out[DATA_W-1:0];
  assign busy_s = ~sync_out[DATA_W];
  assign int_s  = ~sync_out[DATA_W+1];

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer
  dpmb_state_t       state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  dpmb_cmd_t         op, next_op;
  logic [ADDR_W-1:0] next_dev_addr;
  logic [DATA_W-1:0] next_dev_data_out;
  logic              next_port_select_n, next_token_latch_select_n;
  logic              next_write_strobe_n, next_out_enable_n, next_dev_data_oe;
  logic              next_rsp_valid, next_rsp_busy_hit, next_token_owned;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic              busy_seen, next_busy_seen;

  assign cmd_ready    = (state == DPMB_IDLE);
  assign mail_pending = int_s;

  always_comb begin
    next_state                = state;
    next_cnt                  = cnt;
    next_op                   = op;
    next_dev_addr             = dev_addr;
    next_dev_data_out         = dev_data_out;
    next_port_select_n        = port_select_n;
    next_token_latch_select_n = token_latch_select_n;
    next_write_strobe_n       = write_strobe_n;
    next_out_enable_n         = out_enable_n;
    next_dev_data_oe          = dev_data_oe;
    next_rsp_valid            = 1'b0;
    next_rsp_rdata            = rsp_rdata;
    next_rsp_busy_hit         = rsp_busy_hit;
    next_token_owned          = token_owned;
    next_busy_seen            = busy_seen;
    unique case (state)
      DPMB_IDLE: begin
        if (cmd_valid) begin
          next_op        = cmd_op;
          next_busy_seen = 1'b0;
          // token access uses only three address bits and data bit 0
          next_dev_addr  = is_token(cmd_op) ?
                           {{(ADDR_W-TOKEN_ADDR_W){1'b0}}, cmd_addr[TOKEN_ADDR_W-1:0]} :
                           cmd_addr;
          next_dev_data_out = is_token(cmd_op) ?
                              {{(DATA_W-1){1'b0}}, cmd_wdata[TOKEN_BIT]} : cmd_wdata;
          // select low first, strobe later: a strobe-controlled write
          next_port_select_n        = is_token(cmd_op);
          next_token_latch_select_n = ~is_token(cmd_op);
          next_cnt   = CNT_W'(SETUP_CYC);
          next_state = DPMB_SETUP;
        end
      end
      DPMB_SETUP: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_W'(1)) begin
          next_cnt = CNT_W'(PULSE_CYC);
          if (is_write(op)) begin
            // oe stays high so the device never drives during a write
            next_write_strobe_n = 1'b0;
            next_dev_data_oe    = 1'b1;
          end else begin
            next_out_enable_n = 1'b0;
          end
          next_state = DPMB_PULSE;
        end
      end
      DPMB_PULSE: begin
        next_cnt = cnt - 1'b1;
        if (busy_s) begin
          next_busy_seen = 1'b1;
        end
        if (cnt == CNT_W'(1)) begin
          if (!is_write(op) && WAIT_FLOW) begin
            next_cnt   = CNT_W'(FLOW_CYC);
            next_state = DPMB_FLOW;
          end else begin
            next_write_strobe_n = STROBE_IDLE;
            next_cnt            = CNT_W'(HOLD_CYC);
            next_state          = DPMB_HOLD;
          end
        end
      end
      DPMB_FLOW: begin
        next_cnt = cnt - 1'b1;
        if (busy_s) begin
          next_busy_seen = 1'b1;
        end
        if (cnt == CNT_W'(1)) begin
          next_cnt   = CNT_W'(HOLD_CYC);
          next_state = DPMB_HOLD;
        end
      end
      DPMB_HOLD: begin
        // strobe already high; deselect before any address move
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_W'(HOLD_CYC)) begin
          next_port_select_n        = 1'b1;
          next_token_latch_select_n = 1'b1;
          next_out_enable_n         = 1'b1;
          next_dev_data_oe          = 1'b0;
        end
        if (cnt == CNT_W'(1)) begin
          // sync chain lags the pins, so read data is settled only here
          if (!is_write(op)) begin
            next_rsp_rdata = data_s;
          end
          if (op == DPMB_CMD_RD_TOKEN) begin
            next_token_owned = ~data_s[TOKEN_BIT];
          end
          next_rsp_valid    = 1'b1;
          next_rsp_busy_hit = busy_seen;
          next_state        = DPMB_IDLE;
        end
      end
      default: next_state = DPMB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state                <= DPMB_IDLE;
      cnt                  <= '0;
      op                   <= DPMB_CMD_RD_MEM;
      dev_addr             <= '0;
      dev_data_out         <= '0;
      port_select_n        <= 1'b1;
      token_latch_select_n <= 1'b1;
      write_strobe_n       <= STROBE_IDLE;
      out_enable_n         <= 1'b1;
      dev_data_oe          <= 1'b0;
      rsp_valid            <= 1'b0;
      rsp_rdata            <= '0;
      rsp_busy_hit         <= 1'b0;
      token_owned          <= 1'b0;
      busy_seen            <= 1'b0;
    end else begin
      state                <= next_state;
      cnt                  <= next_cnt;
      op                   <= next_op;
      dev_addr             <= next_dev_addr;
      dev_data_out         <= next_dev_data_out;
      port_select_n        <= next_port_select_n;
      token_latch_select_n <= next_token_latch_select_n;
      write_strobe_n       <= next_write_strobe_n;
      out_enable_n         <= next_out_enable_n;
      dev_data_oe          <= next_dev_data_oe;
      rsp_valid            <= next_rsp_valid;
      rsp_rdata            <= next_rsp_rdata;
      rsp_busy_hit         <= next_rsp_busy_hit;
      token_owned          <= next_token_owned;
      busy_seen            <= next_busy_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_write_low;
    !write_strobe_n;
  endsequence

  a_select_exclusive: assert property (@(posedge core_clk) disable iff (!nrst)
    !(!port_select_n && !token_latch_select_n))
    else $error("both selects low");
  a_addr_stable_wr: assert property (@(posedge core_clk) disable iff (!nrst)
    s_write_low |-> $stable(dev_addr))
    else $error("address moved under write strobe");
  a_no_drive_clash: assert property (@(posedge core_clk) disable iff (!nrst)
    dev_data_oe |-> out_enable_n)
    else $error("host drives while device output enabled");
  a_strobe_after_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(write_strobe_n) |-> $past(!port_select_n || !token_latch_select_n))
    else $error("strobe fell before select");
  a_read_both_low: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(out_enable_n) |-> (port_select_n != token_latch_select_n) && write_strobe_n)
    else $error("read without single select");
  a_token_addr: assert property (@(posedge core_clk) disable iff (!nrst)
    !token_latch_select_n |-> dev_addr[ADDR_W-1:TOKEN_ADDR_W] == '0)
    else $error("token address high bits set");
  a_strobe_width: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(write_strobe_n) |-> s_write_low [*2] ##1 !write_strobe_n)
    else $error("write strobe too short");
  a_resp_bounded: assert property (@(posedge core_clk) disable iff (!nrst)
    (cmd_valid && cmd_ready) |-> ##[4:20] rsp_valid)
    else $error("no response in time");
endmodule

// File: bench/dpmb_dev_model.sv
// behavioural dual-port ram device: host on the left port, far port driven by the bench
`timescale 1ns/1ps
module dpmb_dev_model #(
  parameter int  ADDR_W  = 16,
  parameter int  DATA_W  = 9,
  parameter bit  MASTER  = 1'b1,
  parameter int  FLOW_NS = 25
) (
  // host port pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              sel_n,
  input  wire logic              tok_sel_n,
  input  wire logic              wr_n,
  input  wire logic              oe_n,
  input  wire logic [DATA_W-1:0] d_in,
  output logic      [DATA_W-1:0] d_out,
  output logic                   busy_n,
  output logic                   int_n,
  // far port actions
  input  wire logic [ADDR_W-1:0] f_addr,
  input  wire logic [DATA_W-1:0] f_data,
  input  wire logic              f_wr,
  input  wire logic              f_rd,
  input  wire logic              f_tok,
  input  wire logic              f_busy,
  output logic                   f_int_n
);
  localparam logic [ADDR_W-1:0] MB_FAR = '1;
  localparam logic [ADDR_W-1:0] MB_OWN = MB_FAR - 1'b1;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last;
  logic [DATA_W-1:0] tokq;
  logic [7:0]        own_h;
  logic [7:0]        own_f;
  logic [7:0]        req_h;
  logic [7:0]        req_f;
  logic [2:0]        ti;
  logic              f_hot;
  logic              rd_mem;
  logic              rd_tok;
  initial begin
    int_n = 1'b1;
    f_int_n = 1'b1;
    {own_h, own_f, req_h, req_f} = '0;
    {last, tokq, f_hot} = '0;
  end
  assign busy_n = MASTER ? ~f_busy : 1'b1;
  assign rd_mem = !sel_n && !oe_n && wr_n;
  assign rd_tok = !tok_sel_n && sel_n && !oe_n && wr_n;
  // released or unsettled pins show the inverse of the last driven value
  always @* begin
    if (rd_tok) d_out = tokq;
    else if (rd_mem && !(f_hot && addr == f_addr)) d_out = mem[addr];
    else d_out = ~last;
  end
  always @(d_out) if (rd_mem || rd_tok) last = d_out;
  always @(posedge wr_n) begin
    if (!sel_n) begin
      mem[addr] = d_in;
      if (addr == MB_FAR && busy_n) f_int_n = 1'b0;
    end else if (!tok_sel_n) begin
      ti = addr[2:0];
      req_h[ti] = ~d_in[0];
      own_h[ti] = ~d_in[0] & ~own_f[ti];
      if (d_in[0] && req_f[ti]) own_f[ti] = 1'b1;
    end
  end
  always @(negedge oe_n) begin
    if (!tok_sel_n) tokq = {DATA_W{~own_h[addr[2:0]]}};
    if (!sel_n && addr == MB_OWN && busy_n) int_n = 1'b1;
  end
  always @(negedge f_wr) begin
    mem[f_addr] = f_data;
    if (f_addr == MB_OWN) int_n = 1'b0;
    f_hot = 1'b1;
    #FLOW_NS f_hot = 1'b0;
  end
  always @(negedge f_rd) if (f_addr == MB_FAR) f_int_n = 1'b1;
  always @(negedge f_tok) begin
    ti = f_addr[2:0];
    req_f[ti] = ~f_data[0];
    own_f[ti] = ~f_data[0] & ~own_h[ti];
    if (f_data[0] && req_h[ti]) own_h[ti] = 1'b1;
  end
endmodule

// File: bench/tb.sv
// self-checking bench for the dual-port mailbox host controller
`timescale 1ns/1ps
module tb;
  import dpmb_pkg::*;
  logic            core_clk = 1'b0;
  logic            nrst = 1'b0;
  logic            cmd_valid = 1'b0;
  dpmb_cmd_t       cmd_op = DPMB_CMD_RD_MEM;
  logic [15:0]     cmd_addr = '0;
  logic [8:0]      cmd_wdata = '0;
  logic [15:0]     f_addr = '0;
  logic [8:0]      f_data = '0;
  logic            f_wr = 1'b0;
  logic            f_rd = 1'b0;
  logic            f_tok = 1'b0;
  logic            f_busy = 1'b0;
  logic            cmd_ready, rsp_valid, rsp_busy_hit, mail_pending, token_owned;
  logic [8:0]      rsp_rdata, dev_data_in, dev_data_out;
  logic [15:0]     dev_addr;
  logic            port_select_n, token_latch_select_n, write_strobe_n, out_enable_n;
  logic            dev_data_oe, dev_busy_n, dev_int_n, f_int_n;
  int              fails = 0;
  int              comparisons = 0;
  dpmb_host dpmb_host_inst (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
    .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_busy_hit, .mail_pending, .token_owned,
    .dev_addr, .port_select_n, .token_latch_select_n, .write_strobe_n, .out_enable_n,
    .dev_data_in, .dev_data_out, .dev_data_oe, .dev_busy_n, .dev_int_n);
  dpmb_dev_model dpmb_dev_model_inst (.addr(dev_addr), .sel_n(port_select_n),
    .tok_sel_n(token_latch_select_n), .wr_n(write_strobe_n), .oe_n(out_enable_n),
    .d_in(dev_data_out), .d_out(dev_data_in), .busy_n(dev_busy_n), .int_n(dev_int_n),
    .f_addr, .f_data, .f_wr, .f_rd, .f_tok, .f_busy, .f_int_n);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_cmd(input dpmb_cmd_t op, input logic [15:0] a, input logic [8:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    check(n < 40, 1'b1);
  endtask
  // far port: 0 write, 1 read, 2 token write; then let the sync chain settle
  task automatic far(input int k, input logic [15:0] a, input logic [8:0] d);
    @(posedge core_clk);
    f_addr <= a;
    f_data <= d;
    f_wr <= (k == 0);
    f_rd <= (k == 1);
    f_tok <= (k == 2);
    @(posedge core_clk);
    {f_wr, f_rd, f_tok} <= 3'b000;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic t_mem;
    do_cmd(DPMB_CMD_WR_MEM, 16'h1234, 9'h1a5);
    do_cmd(DPMB_CMD_WR_MEM, 16'h1235, 9'h05a);
    do_cmd(DPMB_CMD_RD_MEM, 16'h1234, 9'h000);
    check(rsp_rdata, 9'h1a5);
    check(rsp_busy_hit, 1'b0);
    far(0, 16'h0042, 9'h0c7);
    do_cmd(DPMB_CMD_RD_MEM, 16'h0042, 9'h000);
    check(rsp_rdata, 9'h0c7);
    // far write lands while the host read is already under way
    fork
      do_cmd(DPMB_CMD_RD_MEM, 16'h0043, 9'h000);
      far(0, 16'h0043, 9'h0a6);
    join
    check(rsp_rdata, 9'h0a6);
  endtask
  task automatic t_mail_out;
    do_cmd(DPMB_CMD_WR_MEM, 16'hffff, 9'h033);
    check(f_int_n, 1'b0);
    far(1, 16'hffff, 9'h000);
    f_busy <= 1'b1;
    do_cmd(DPMB_CMD_WR_MEM, 16'hffff, 9'h034);
    check(f_int_n, 1'b1);
    check(rsp_busy_hit, 1'b1);
    f_busy <= 1'b0;
  endtask
  task automatic t_mail_in;
    far(0, 16'hfffe, 9'h0c3);
    check({mail_pending, dev_int_n}, 2'b10);
    do_cmd(DPMB_CMD_RD_MEM, 16'hffff, 9'h000);
    check(mail_pending, 1'b1);
    f_busy <= 1'b1;
    do_cmd(DPMB_CMD_RD_MEM, 16'hfffe, 9'h000);
    check(mail_pending, 1'b1);
    f_busy <= 1'b0;
    do_cmd(DPMB_CMD_RD_MEM, 16'hfffe, 9'h000);
    check(rsp_rdata, 9'h0c3);
    check(mail_pending, 1'b0);
  endtask
  task automatic t_token;
    do_cmd(DPMB_CMD_WR_TOKEN, 16'hfff5, 9'h1fe);
    do_cmd(DPMB_CMD_RD_TOKEN, 16'h0005, 9'h000);
    check(rsp_rdata, 9'h000);
    check(token_owned, 1'b1);
    far(2, 16'h0005, 9'h000);
    do_cmd(DPMB_CMD_WR_TOKEN, 16'h0005, 9'h001);
    do_cmd(DPMB_CMD_RD_TOKEN, 16'h0005, 9'h000);
    check(rsp_rdata, 9'h1ff);
    check(token_owned, 1'b0);
    far(2, 16'h0005, 9'h001);
  endtask
  always @(posedge core_clk) begin
    if (nrst) begin
      check(!port_select_n && !token_latch_select_n, 1'b0);
      check(dev_data_oe && !out_enable_n, 1'b0);
    end
  end
  initial begin
    #(30000 * 8);
    fails++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_mem;
    t_mail_out;
    t_mail_in;
    t_token;
    repeat (4) @(posedge core_clk);
    finish_test;
  end
endmodule
